//--- common/sar_adc_pkg.sv
`default_nettype none
package sar_adc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POWERUP = 2'b01,
        ST_CONVERT = 2'b10,
        ST_GAP = 2'b11
    } seq_state_e;

    typedef enum logic [2:0] {
        RPT_1 = 3'b000,
        RPT_4 = 3'b001,
        RPT_8 = 3'b010,
        RPT_16 = 3'b011,
        RPT_32 = 3'b100,
        RPT_64 = 3'b101
    } repeat_count_e;

    typedef logic [15:0] result_t;

endpackage
`default_nettype wire

//--- common/sar_adc_regs.svh
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// byte offsets of the register words
`define REG_CTRL 8'h00
`define REG_CHANNEL 8'h04
`define REG_ACCUM_CFG 8'h08
`define REG_RESULT_HIGH_BYTE 8'h0C
`define REG_RESULT_LOW_BYTE 8'h10
`define REG_STATUS 8'h14
`define REG_INT_STATUS 8'h18
`define REG_INT_MASK 8'h1C
`define REG_WIN_LOW 8'h20
`define REG_WIN_HIGH 8'h24

// control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_BURST_BIT 1
`define CTRL_START_BIT 2

// accumulator_config fields
`define ACFG_RPT_LSB 0
`define ACFG_FMT_LSB 4

// interrupt status bits
`define INT_DONE_BIT 0
`define INT_WINDOW_BIT 1

// input channel codes
`define CH_PAD 5'h00
`define CH_TEMP 5'h1B
`define CH_SUPPLY 5'h1C
`define CH_REGULATOR 5'h1D
`define CH_GROUND 5'h1F

// reset values
`define RST_WIN_LOW 16'h0000
`define RST_WIN_HIGH 16'hFFFF
`define RST_RESULT 16'h0000

// power-up counter target; a burst spends this plus one cycle powering the converter up
`define POWERUP_CYCLES 3'h4

`endif

//--- logic/sar_accumulator.sv
`timescale 1ns/1ns
`default_nettype none
module sar_accumulator
    import sar_adc_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic clear, // start of a new series
    input wire logic add, // one conversion code arrives
    input wire logic [9:0] code, // conversion code
    input wire logic [2:0] result_format_select, // justification and shift
    output result_t acc_sum, // running sum
    output result_t formatted_next // formatted sum including this code
);
    result_t acc_q;
    result_t acc_d;
    result_t sum_now;
    result_t left_just;
    result_t right_shift;

    // unsigned sum; 64 full-scale codes still fit in 16 bits
    assign sum_now = add ? 16'(acc_q + {6'h00, code}) : acc_q;
    assign acc_d = clear ? 16'h0000 : sum_now;
    assign left_just = {sum_now[9:0], 6'h00};
    assign right_shift = sum_now >> result_format_select[1:0];
    // bits of the pair outside the placed code stay zero
    assign formatted_next = result_format_select[2] ? left_just : right_shift;
    assign acc_sum = acc_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_q <= 16'h0000;
        end else begin
            acc_q <= acc_d;
        end
    end

    chk_acc_adds: assert property (@(posedge sys_clk) disable iff (rst)
        add && !clear |=> acc_q == 16'($past(acc_q) + {6'h00, $past(code)}))
        else $error("accumulator did not add the code");

    chk_acc_clears: assert property (@(posedge sys_clk) disable iff (rst)
        clear |=> acc_q == 16'h0000)
        else $error("accumulator not cleared at series start");

endmodule // sar_accumulator
`default_nettype wire

//--- logic/sar_adc_result_formatter.sv
// Notes on behaviour
// - channel code routes pad, temp, supply, regulator, ground
// - result split into high and low bytes
// - single conversion gives unsigned 10-bit code
// - format 000 right, 100 left justified
// - unused result bits read as zero
// - series sum updates result only at end
// - repeat counts 1,4,8,16,32,64, unsigned sums
// - 16-bit accumulator sums codes without software
// - format shifts sum right by 1-3
// - burst powers up, converts, powers down alone
// - done flag only after full repeat count
// - busy fall at the end of a series sets done and interrupt
// - window compares only after full count
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_regs.svh"
module sar_adc_result_formatter
    import sar_adc_pkg::*;
(
    input wire logic sys_clk, // 25 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [7:0] address, // avalon byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [31:0] writedata, // avalon write data
    input wire logic [3:0] byteenable, // avalon byte enables
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest, // avalon wait request
    input wire logic sample_valid, // converter finished one code
    input wire logic [9:0] sample_code, // converter code
    output logic conv_start, // one-cycle start to converter
    output logic conv_power, // converter powered
    output logic conv_busy, // conversion_busy_bit
    output logic [4:0] channel_route, // one-hot input route
    output logic irq // level interrupt
);
    // bus slave
    logic waitreq_q;
    logic waitreq_d;
    logic [31:0] readdata_q;
    logic [31:0] rd_mux;
    wire wr_fire = write && !waitreq_q;
    wire rd_take = read && waitreq_q;
    wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire [31:0] wd_m = writedata & be_mask;
    wire hit_ctrl = wr_fire && address == `REG_CTRL;
    wire hit_chan = wr_fire && address == `REG_CHANNEL;
    wire hit_acfg = wr_fire && address == `REG_ACCUM_CFG;
    wire hit_isr = wr_fire && address == `REG_INT_STATUS;
    wire hit_imask = wr_fire && address == `REG_INT_MASK;
    wire hit_wlo = wr_fire && address == `REG_WIN_LOW;
    wire hit_whi = wr_fire && address == `REG_WIN_HIGH;

    // software state
    logic conv_enable_q;
    logic burst_enable_q;
    logic [4:0] input_channel_select_q;
    logic [2:0] repeat_count_select_q;
    logic [2:0] result_format_select_q;
    result_t result_q;
    result_t win_low_q;
    result_t win_high_q;
    logic [1:0] int_status_q;
    logic [1:0] int_status_d;
    logic [1:0] int_mask_q;
    logic irq_q;

    // sequencer
    seq_state_e state_q;
    seq_state_e state_d;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [2:0] pw_cnt_q;
    logic start_q;
    logic start_d;
    logic busy_q;
    logic power_q;
    logic [4:0] route_q;
    logic series_clear;

    result_t formatted_next;

    wire start_req = hit_ctrl && byteenable[0] && writedata[`CTRL_START_BIT];
    wire run_ok = conv_enable_q || burst_enable_q;
    wire accum_add = state_q == ST_CONVERT && sample_valid;

    // series length decode; unused codes fall back to single conversions
    wire [6:0] rpt_target =
        (repeat_count_select_q == RPT_4) ? 7'h04 :
        (repeat_count_select_q == RPT_8) ? 7'h08 :
        (repeat_count_select_q == RPT_16) ? 7'h10 :
        (repeat_count_select_q == RPT_32) ? 7'h20 :
        (repeat_count_select_q == RPT_64) ? 7'h40 : 7'h01;

    wire series_last = accum_add && 7'(cnt_q + 7'h01) == rpt_target;
    wire in_window = formatted_next >= win_low_q && formatted_next <= win_high_q;

    // only the five documented codes reach the mux; reserved codes select nothing
    wire [4:0] route_d = {
        input_channel_select_q == `CH_GROUND,
        input_channel_select_q == `CH_REGULATOR,
        input_channel_select_q == `CH_SUPPLY,
        input_channel_select_q == `CH_TEMP,
        input_channel_select_q == `CH_PAD};

    sar_accumulator u_acc (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(series_clear),
        .add(accum_add),
        .code(sample_code),
        .result_format_select(result_format_select_q),
        .acc_sum(),
        .formatted_next(formatted_next)
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        start_d = 1'b0;
        series_clear = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_req && run_ok) begin
                    series_clear = 1'b1;
                    cnt_d = 7'h00;
                    if (burst_enable_q && !conv_enable_q) begin
                        state_d = ST_POWERUP;
                    end else begin
                        state_d = ST_CONVERT;
                        start_d = 1'b1;
                    end
                end
            end
            ST_POWERUP: begin
                if (pw_cnt_q == `POWERUP_CYCLES) begin
                    state_d = ST_CONVERT;
                    start_d = 1'b1;
                end
            end
            ST_CONVERT: begin
                if (accum_add) begin
                    cnt_d = 7'(cnt_q + 7'h01);
                    if (series_last) begin
                        state_d = ST_IDLE;
                    end else if (burst_enable_q) begin
                        // burst runs the whole series from one start
                        start_d = 1'b1;
                    end else begin
                        state_d = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                // without burst every conversion waits for its own start
                if (start_req) begin
                    state_d = ST_CONVERT;
                    start_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // done and window events come only from the last code of a series
    wire [1:0] int_set = {series_last && in_window, series_last};
    wire [1:0] int_clr = hit_isr ? wd_m[1:0] : 2'b00;
    // a set in the same cycle as a write-one-to-clear wins
    assign int_status_d = (int_status_q & ~int_clr) | int_set;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 7'h00;
            pw_cnt_q <= 3'h0;
            start_q <= 1'b0;
            busy_q <= 1'b0;
            power_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pw_cnt_q <= (state_q == ST_POWERUP) ? 3'(pw_cnt_q + 3'h1) : 3'h0;
            start_q <= start_d;
            busy_q <= state_d == ST_CONVERT;
            // burst alone keeps the converter up only while a series runs
            power_q <= conv_enable_q || state_d != ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_q <= `RST_RESULT;
        end else if (series_last) begin
            result_q <= formatted_next;
        end
    end

    assign waitreq_d = !(waitreq_q && (read || write));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conv_enable_q <= 1'b0;
            burst_enable_q <= 1'b0;
            input_channel_select_q <= `CH_PAD;
            repeat_count_select_q <= RPT_1;
            result_format_select_q <= 3'b000;
            int_mask_q <= 2'b00;
        end else begin
            if (hit_ctrl && byteenable[0]) begin
                conv_enable_q <= writedata[`CTRL_ENABLE_BIT];
                burst_enable_q <= writedata[`CTRL_BURST_BIT];
            end
            if (hit_chan && byteenable[0]) begin
                input_channel_select_q <= writedata[4:0];
            end
            if (hit_acfg && byteenable[0]) begin
                repeat_count_select_q <= writedata[`ACFG_RPT_LSB +: 3];
                result_format_select_q <= writedata[`ACFG_FMT_LSB +: 3];
            end
            if (hit_imask && byteenable[0]) begin
                int_mask_q <= writedata[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            win_low_q <= `RST_WIN_LOW;
            win_high_q <= `RST_WIN_HIGH;
        end else begin
            if (hit_wlo) begin
                win_low_q <= (win_low_q & ~be_mask[15:0]) | wd_m[15:0];
            end
            if (hit_whi) begin
                win_high_q <= (win_high_q & ~be_mask[15:0]) | wd_m[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_status_q <= 2'b00;
            irq_q <= 1'b0;
            route_q <= 5'h00;
        end else begin
            int_status_q <= int_status_d;
            irq_q <= |(int_status_d & int_mask_q);
            route_q <= route_d;
        end
    end

    // each result byte sits in the low lane of its own word
    always_comb begin
        case (address)
            `REG_CTRL: rd_mux = {30'h0000_0000, burst_enable_q, conv_enable_q};
            `REG_CHANNEL: rd_mux = {27'h000_0000, input_channel_select_q};
            `REG_ACCUM_CFG: rd_mux = {25'h000_0000, result_format_select_q, 1'b0, repeat_count_select_q};
            `REG_RESULT_HIGH_BYTE: rd_mux = {24'h00_0000, result_q[15:8]};
            `REG_RESULT_LOW_BYTE: rd_mux = {24'h00_0000, result_q[7:0]};
            `REG_STATUS: rd_mux = {16'h0000, 1'b0, cnt_q, 4'h0, state_q, power_q, busy_q};
            `REG_INT_STATUS: rd_mux = {30'h0000_0000, int_status_q};
            `REG_INT_MASK: rd_mux = {30'h0000_0000, int_mask_q};
            `REG_WIN_LOW: rd_mux = {16'h0000, win_low_q};
            `REG_WIN_HIGH: rd_mux = {16'h0000, win_high_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            waitreq_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else begin
            waitreq_q <= waitreq_d;
            if (rd_take) begin
                readdata_q <= rd_mux;
            end
        end
    end

    assign readdata = readdata_q;
    assign waitrequest = waitreq_q;
    assign conv_start = start_q;
    assign conv_power = power_q;
    assign conv_busy = busy_q;
    assign channel_route = route_q;
    assign irq = irq_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_route_decode: assert property (
        input_channel_select_q == `CH_TEMP ##1 input_channel_select_q == `CH_TEMP
        |=> channel_route == 5'b00010)
        else $error("temperature code did not route the sensor");

    chk_route_reserved: assert property (
        !(input_channel_select_q inside {`CH_PAD, `CH_TEMP, `CH_SUPPLY, `CH_REGULATOR, `CH_GROUND})
        |=> channel_route == 5'b00000)
        else $error("reserved channel code routed an input");

    chk_result_bytes: assert property (
        rd_take && address == `REG_RESULT_HIGH_BYTE
        |=> readdata == {24'h00_0000, $past(result_q[15:8])} && !waitrequest)
        else $error("high result byte read back wrong");

    chk_single_right: assert property (
        series_last && repeat_count_select_q == RPT_1 && result_format_select_q == 3'b000
        |=> result_q == {6'h00, $past(sample_code)})
        else $error("single right-justified result wrong");

    chk_left_just: assert property (
        series_last && repeat_count_select_q == RPT_1 && result_format_select_q == 3'b100
        |=> result_q == {$past(sample_code), 6'h00})
        else $error("left-justified result wrong");

    chk_result_held: assert property (
        state_q != ST_IDLE && !series_last |=> $stable(result_q))
        else $error("result changed before the series ended");

    chk_series_length: assert property (
        series_last |-> cnt_q == 7'(rpt_target - 7'h01))
        else $error("series ended at the wrong count");

    chk_done_late: assert property (
        $rose(int_status_q[`INT_DONE_BIT]) |-> $past(series_last))
        else $error("done flag set before the series completed");

    chk_busy_done: assert property (
        series_last |=> !conv_busy && int_status_q[`INT_DONE_BIT])
        else $error("busy fall did not set the done flag");

    chk_window_late: assert property (
        $rose(int_status_q[`INT_WINDOW_BIT]) |-> $past(series_last))
        else $error("window event outside a series end");

    chk_burst_power: assert property (
        series_last && burst_enable_q && !conv_enable_q |=> ##1 !conv_power)
        else $error("burst left the converter powered");

    chk_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle wide");

    cov_burst_series: cover property (
        burst_enable_q && repeat_count_select_q == RPT_4 && series_last);
    cov_shift_three: cover property (
        series_last && result_format_select_q == 3'b011 && repeat_count_select_q == RPT_64);
    cov_done_irq: cover property (series_last ##1 irq);

endmodule // sar_adc_result_formatter
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_regs.svh"
module tb_top;
    import sar_adc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    logic sample_valid = 1'b0;
    logic [9:0] sample_code = 10'h000;
    logic conv_start;
    logic conv_power;
    logic conv_busy;
    logic [4:0] channel_route;
    logic irq;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int fixed_code = -1;
    int wait_n = 0;
    int cv = 0;
    int codes[$];
    result_t prev = 16'h0000;
    logic [15:0] win_low = 16'h0200;
    logic [7:0] rst_addr [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
    logic [31:0] rst_val [11] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h0000_ffff, 0};
    logic [4:0] ch_code [7] = '{`CH_PAD, `CH_TEMP, `CH_SUPPLY, `CH_REGULATOR, `CH_GROUND, 5'h01, 5'h1e};
    logic [4:0] ch_route [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h00};

    sar_adc_result_formatter sar_adc_result_formatter_i (
        .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .sample_valid(sample_valid), .sample_code(sample_code), .conv_start(conv_start),
        .conv_power(conv_power), .conv_busy(conv_busy), .channel_route(channel_route), .irq(irq)
    );

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD register t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD port t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one idle edge after each transfer so no strobe is assigned twice in a step
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        address <= a;
        read <= 1'b1;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0) @(posedge sys_clk);
        chk_reg(readdata, exp);
        read <= 1'b0;
        @(posedge sys_clk);
    endtask

    // converter stand-in: answers each start after 2..5 cycles
    always @(posedge sys_clk) begin
        sample_valid <= 1'b0;
        if (conv_start === 1'b1) begin
            chk_pin({31'b0, conv_power}, 32'h0000_0001);
            wait_n <= 2 + int'($urandom % 4);
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
            if (wait_n == 1) begin
                cv = (fixed_code >= 0) ? fixed_code : int'($urandom % 1024);
                sample_valid <= 1'b1;
                sample_code <= cv[9:0];
                codes.push_back(cv);
            end
        end
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    function automatic result_t expect_res(input logic [2:0] fmt);
        int s = 0;
        logic [15:0] s16;
        foreach (codes[i]) s += codes[i];
        s16 = s[15:0];
        if (fmt[2]) return {s16[9:0], 6'b0};
        return s16 >> fmt[1:0];
    endfunction

    task automatic run_series(input logic [1:0] mode, input logic [2:0] rpt, input logic [2:0] fmt, input logic m);
        result_t exp;
        int n;
        n = (rpt == 3'b000) ? 1 : (2 << rpt);
        bus_write(`REG_ACCUM_CFG, {25'b0, fmt, 1'b0, rpt});
        bus_write(`REG_INT_MASK, {31'b0, m});
        bus_write(`REG_INT_STATUS, 32'h0000_0003);
        codes.delete();
        // the start bit is judged against the enables already stored, so set them first
        bus_write(`REG_CTRL, {30'b0, mode});
        bus_write(`REG_CTRL, {29'b0, 1'b1, mode});
        for (int i = 0; i < 20 && conv_busy !== 1'b1; i++) @(posedge sys_clk);
        if (n > 1) begin
            rd_chk(`REG_INT_STATUS, 32'h0000_0000);
            rd_chk(`REG_RESULT_LOW_BYTE, {24'b0, prev[7:0]});
        end
        // without burst every further code of the series needs its own start
        for (int j = 1; j < n && mode[1] == 1'b0; j++) begin
            for (int i = 0; i < 100 && conv_busy !== 1'b0; i++) @(posedge sys_clk);
            bus_write(`REG_CTRL, {29'b0, 1'b1, mode});
        end
        for (int i = 0; i < 3000 && conv_busy !== 1'b0; i++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        exp = expect_res(fmt);
        chk_pin({31'b0, irq}, {31'b0, m});
        chk_reg(32'(codes.size()), 32'(n));
        rd_chk(`REG_RESULT_HIGH_BYTE, {24'b0, exp[15:8]});
        rd_chk(`REG_RESULT_LOW_BYTE, {24'b0, exp[7:0]});
        rd_chk(`REG_INT_STATUS, {30'b0, exp >= win_low, 1'b1});
        if (mode[0] == 1'b0) begin
            chk_pin({31'b0, conv_power}, 32'h0000_0000);
        end
        prev = exp;
    endtask

    initial begin
        logic [2:0] r;
        logic [2:0] f;
        void'($urandom(32'hbbd23b40));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i]);
        // read-only and unmapped places must swallow writes
        bus_write(`REG_RESULT_HIGH_BYTE, 32'h0000_00ab);
        bus_write(8'h30, 32'hffff_ffff);
        rd_chk(`REG_RESULT_HIGH_BYTE, 32'h0000_0000);
        rd_chk(8'h30, 32'h0000_0000);
        // pad selector registers sit outside; one input code is chosen at a time
        foreach (ch_code[i]) begin
            bus_write(`REG_CHANNEL, {27'b0, ch_code[i]});
            repeat (2) @(posedge sys_clk);
            chk_pin({27'b0, channel_route}, {27'b0, ch_route[i]});
        end
        bus_write(`REG_WIN_LOW, {16'b0, win_low});
        fixed_code = 1023;
        run_series(2'b01, 3'b000, 3'b000, 1'b1);
        run_series(2'b01, 3'b000, 3'b100, 1'b0);
        fixed_code = 512;
        run_series(2'b01, 3'b000, 3'b100, 1'b1);
        fixed_code = 1023;
        for (int k = 1; k < 6; k++) begin
            run_series(2'b10, 3'(k), 3'b000, 1'b0);
        end
        fixed_code = -1;
        run_series(2'b01, 3'b001, 3'b001, 1'b1);
        for (int k = 0; k < 16; k++) begin
            r = 3'($urandom % 6);
            f = (r == 3'b000) ? 3'($urandom % 8) : 3'($urandom % 4);
            if (r == 3'b000) begin
                run_series(2'b01, r, f, 1'($urandom % 2));
            end else begin
                run_series({1'b1, 1'($urandom % 2)}, r, f, 1'($urandom % 2));
            end
        end
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
